//--- hw/ats_serial.sv
// Behaviour
// RULE1: Shift register bytes leave on the transmit pin, bit 0 first.
// RULE2: After a byte, next FIFO byte loads and sends without software.
// RULE3: Shift register has no CPU read or write path.
// RULE4: Transmit FIFO holds sixteen eight-bit entries.
// RULE5: Empty shift register plus FIFO data: load oldest, send back to back.
// RULE6: Writes to a full FIFO are dropped, contents unchanged.
// RULE7: FIFO writes accepted in any transmitter state.
// RULE8: Format register clears on reset and standby; always readable and writable.
// RULE9: Bit 6 picks eight data bits at 0, seven at 1.
// RULE10: Seven-bit mode leaves bit 7 of each byte unsent.
// RULE11: Bit 5 adds parity on transmit and checks it on receive.
// RULE12: Bit 4 picks even at 0, odd at 1; ignored without parity.
// RULE13: Even parity: data plus parity hold an even count of ones.
// RULE14: Odd parity: data plus parity hold an odd count of ones.
// RULE15: Bit 3 sends one high stop bit at 0, two at 1.
// RULE16: Receive checks first stop only; low second stop is next start.
// RULE17: Bits 1:0 prescale baud clock by 1, 4, 16 or 64.
// RULE18: Bits 7 and 2 of the format register read as zero.
// RULE19: Transmitter enabled, output starts once FIFO holds data.
// RULE20: Frames open with one low start bit; line rests high otherwise.
`timescale 1ns/1ns
`default_nettype none
module ats_serial #(
  parameter int unsigned DATA_W     = 8,
  parameter int unsigned FIFO_DEPTH = 16,
  parameter int unsigned CNT_W      = 5
) (
  input  wire logic                       i_mclk,
  input  wire logic                       i_rst,
  input  wire logic                       i_standby,
  input  wire logic [ats_pkg::ADDR_W-1:0] i_addr,
  input  wire logic [7:0]                 i_wdata,
  input  wire logic                       i_wr,
  input  wire logic                       i_rd,
  output logic      [7:0]                 o_rdata,
  input  wire logic                       i_rxd,
  output logic                            o_txd,
  output logic                            o_tx_busy
);

  function automatic logic [15:0] bit_len(input logic [7:0] fmt, input logic [7:0] brate);
    logic [6:0] pre;
    pre = ats_pkg::PRE_64;
    if (fmt[ats_pkg::FMT_CKSH:ats_pkg::FMT_CKSL] == ats_pkg::CKS_DIV1) begin
      pre = ats_pkg::PRE_1;
    end else if (fmt[ats_pkg::FMT_CKSH:ats_pkg::FMT_CKSL] == ats_pkg::CKS_DIV4) begin
      pre = ats_pkg::PRE_4;
    end else if (fmt[ats_pkg::FMT_CKSH:ats_pkg::FMT_CKSL] == ats_pkg::CKS_DIV16) begin
      pre = ats_pkg::PRE_16;
    end
    // One bit lasts (brate + 1) prescaled ticks [RULE17]
    return 16'({8'h00, brate} + 16'h0001) * 16'(pre);
  endfunction : bit_len

  logic [7:0] fmt_q, fmt_d;
  logic [7:0] ctl_q, ctl_d;
  logic [7:0] brate_q, brate_d;
  logic       perr_q, perr_d;
  logic       ferr_q, ferr_d;
  logic [7:0] rxbuf_q, rxbuf_d;
  logic [7:0] rdata_q, rdata_d;

  logic [DATA_W-1:0] mem_q [FIFO_DEPTH];
  logic [DATA_W-1:0] mem_d [FIFO_DEPTH];
  logic [CNT_W-2:0]  wp_q, wp_d, rp_q, rp_d;
  logic [CNT_W-1:0]  cnt_q, cnt_d;
  logic              push, pop, fifo_clr, fifo_empty;

  ats_pkg::ats_tx_state_e tx_q, tx_d;
  logic [DATA_W-1:0] sh_q, sh_d;
  logic [15:0]       tcnt_q, tcnt_d;
  logic [3:0]        tbit_q, tbit_d;
  logic [3:0]        tnb_q, tnb_d;
  logic              tpar_q, tpar_d;
  logic              tpe_q, tpe_d;
  logic              tst2_q, tst2_d;
  logic              tsec_q, tsec_d;
  logic              txd_q, txd_d;
  logic              ld_ok;
  logic [DATA_W-1:0] head;
  logic [15:0]       blen;

  logic              rs1_q, rs2_q, rs3_q, rlvl_q, rlvl_d, rprev_q;
  ats_pkg::ats_rx_state_e rx_q, rx_d;
  logic [7:0]        rsh_q, rsh_d;
  logic [15:0]       rcnt_q, rcnt_d;
  logic [3:0]        rbit_q, rbit_d;
  logic              racc_q, racc_d;
  logic              rdone, rperr, rferr;
  logic [7:0]        rbyte;

  assign blen       = bit_len(fmt_q, brate_q);
  assign fifo_empty = (cnt_q == '0);
  assign fifo_clr   = i_wr && (i_addr == ats_pkg::A_CTRL) && i_wdata[ats_pkg::CTL_FRST];
  // Full FIFO drops the write; no busy check on the transmitter [RULE6] [RULE7]
  assign push       = i_wr && (i_addr == ats_pkg::A_TXPORT) && (cnt_q != CNT_W'(FIFO_DEPTH));
  assign head       = mem_q[rp_q];
  assign ld_ok      = ctl_q[ats_pkg::CTL_TXON] && !fifo_empty; // [RULE19]

  // Registers
  always_comb begin
    fmt_d   = fmt_q;
    ctl_d   = ctl_q;
    brate_d = brate_q;
    perr_d  = perr_q;
    ferr_d  = ferr_q;
    rxbuf_d = rxbuf_q;
    rdata_d = 8'h00;
    if (i_wr) begin
      if (i_addr == ats_pkg::A_FMT) begin
        fmt_d = i_wdata & ats_pkg::FMT_WMASK; // [RULE8] [RULE18]
      end else if (i_addr == ats_pkg::A_CTRL) begin
        ctl_d = i_wdata & ats_pkg::CTL_WMASK;
      end else if (i_addr == ats_pkg::A_BRATE) begin
        brate_d = i_wdata;
      end else if (i_addr == ats_pkg::A_STAT) begin
        if (i_wdata[ats_pkg::ST_PERR]) begin
          perr_d = 1'b0;
        end
        if (i_wdata[ats_pkg::ST_FERR]) begin
          ferr_d = 1'b0;
        end
      end
    end
    // Set after clear so a same-cycle event is kept
    if (rdone) begin
      rxbuf_d = rbyte;
      if (rperr) begin
        perr_d = 1'b1;
      end
      if (rferr) begin
        ferr_d = 1'b1;
      end
    end
    if (i_rd) begin
      // Shift register has no address here [RULE3]
      if (i_addr == ats_pkg::A_FMT) begin
        rdata_d = fmt_q; // [RULE18]
      end else if (i_addr == ats_pkg::A_CTRL) begin
        rdata_d = ctl_q;
      end else if (i_addr == ats_pkg::A_BRATE) begin
        rdata_d = brate_q;
      end else if (i_addr == ats_pkg::A_STAT) begin
        rdata_d                  = 8'(cnt_q);
        rdata_d[ats_pkg::ST_IDLE] = (tx_q == ats_pkg::TX_IDLE);
        rdata_d[ats_pkg::ST_PERR] = perr_q;
        rdata_d[ats_pkg::ST_FERR] = ferr_q;
      end else if (i_addr == ats_pkg::A_RXDATA) begin
        rdata_d = rxbuf_q;
      end
    end
    if (i_standby) begin
      fmt_d = ats_pkg::FMT_RST; // [RULE8]
      ctl_d = ats_pkg::CTL_RST;
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      fmt_q   <= ats_pkg::FMT_RST; // [RULE8]
      ctl_q   <= ats_pkg::CTL_RST;
      brate_q <= ats_pkg::BRATE_RST;
      perr_q  <= 1'b0;
      ferr_q  <= 1'b0;
      rxbuf_q <= 8'h00;
      rdata_q <= 8'h00;
    end else begin
      fmt_q   <= fmt_d;
      ctl_q   <= ctl_d;
      brate_q <= brate_d;
      perr_q  <= perr_d;
      ferr_q  <= ferr_d;
      rxbuf_q <= rxbuf_d;
      rdata_q <= rdata_d;
    end
  end

  assign o_rdata = rdata_q;

  // Transmit FIFO
  always_comb begin
    mem_d = mem_q;
    wp_d  = wp_q;
    rp_d  = rp_q;
    cnt_d = cnt_q;
    if (fifo_clr || i_standby) begin
      wp_d  = '0;
      rp_d  = '0;
      cnt_d = '0;
    end else begin
      if (push) begin
        mem_d[wp_q] = i_wdata; // [RULE4]
        wp_d        = wp_q + 1'b1;
      end
      if (pop) begin
        rp_d = rp_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_d = cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_d = cnt_q - 1'b1;
      end
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      for (int i = 0; i < FIFO_DEPTH; i++) begin
        mem_q[i] <= '0;
      end
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      mem_q <= mem_d;
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      cnt_q <= cnt_d;
    end
  end

  // Transmitter
  always_comb begin
    tx_d   = tx_q;
    sh_d   = sh_q;
    tcnt_d = tcnt_q;
    tbit_d = tbit_q;
    tnb_d  = tnb_q;
    tpar_d = tpar_q;
    tpe_d  = tpe_q;
    tst2_d = tst2_q;
    tsec_d = tsec_q;
    txd_d  = txd_q;
    pop    = 1'b0;
    case (tx_q)
      ats_pkg::TX_IDLE: begin
        txd_d = 1'b1; // [RULE20]
        if (ld_ok) begin
          pop = 1'b1; // [RULE5]
        end
      end
      ats_pkg::TX_START: begin
        if (tcnt_q != '0) begin
          tcnt_d = tcnt_q - 16'h0001;
        end else begin
          tx_d   = ats_pkg::TX_DATA;
          tcnt_d = blen - 16'h0001;
          txd_d  = sh_q[0]; // [RULE1]
          sh_d   = sh_q >> 1;
          tbit_d = 4'h1;
        end
      end
      ats_pkg::TX_DATA: begin
        if (tcnt_q != '0) begin
          tcnt_d = tcnt_q - 16'h0001;
        end else begin
          tcnt_d = blen - 16'h0001;
          if (tbit_q == tnb_q) begin
            if (tpe_q) begin
              tx_d  = ats_pkg::TX_PAR; // [RULE11]
              txd_d = tpar_q;
            end else begin
              tx_d   = ats_pkg::TX_STOP;
              txd_d  = 1'b1;
              tsec_d = 1'b0;
            end
          end else begin
            txd_d  = sh_q[0]; // [RULE1]
            sh_d   = sh_q >> 1;
            tbit_d = tbit_q + 4'h1;
          end
        end
      end
      ats_pkg::TX_PAR: begin
        if (tcnt_q != '0) begin
          tcnt_d = tcnt_q - 16'h0001;
        end else begin
          tx_d   = ats_pkg::TX_STOP;
          tcnt_d = blen - 16'h0001;
          txd_d  = 1'b1;
          tsec_d = 1'b0;
        end
      end
      ats_pkg::TX_STOP: begin
        if (tcnt_q != '0) begin
          tcnt_d = tcnt_q - 16'h0001;
        end else if (tst2_q && !tsec_q) begin
          tsec_d = 1'b1; // [RULE15]
          tcnt_d = blen - 16'h0001;
        end else if (ld_ok) begin
          pop = 1'b1; // [RULE2] [RULE5]
        end else begin
          tx_d  = ats_pkg::TX_IDLE;
          txd_d = 1'b1;
        end
      end
      default: begin
        tx_d  = ats_pkg::TX_IDLE;
        txd_d = 1'b1;
      end
    endcase
    if (pop) begin
      // Length, parity and stop format are sampled per character; the prescale bits still set every bit's length
      tx_d   = ats_pkg::TX_START;
      tcnt_d = blen - 16'h0001;
      txd_d  = 1'b0; // [RULE20]
      sh_d   = head;
      tnb_d  = ats_pkg::NBITS_8;
      if (fmt_q[ats_pkg::FMT_CHR]) begin
        sh_d[DATA_W-1] = 1'b0; // [RULE9] [RULE10]
        tnb_d          = ats_pkg::NBITS_7;
      end
      // Odd flag only matters when parity is on [RULE12] [RULE13] [RULE14]
      tpar_d = (^sh_d) ^ fmt_q[ats_pkg::FMT_OE];
      tpe_d  = fmt_q[ats_pkg::FMT_PE];
      tst2_d = fmt_q[ats_pkg::FMT_STOP];
      tsec_d = 1'b0;
    end
    if (i_standby) begin
      tx_d  = ats_pkg::TX_IDLE;
      txd_d = 1'b1;
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      tx_q   <= ats_pkg::TX_IDLE;
      sh_q   <= '0;
      tcnt_q <= '0;
      tbit_q <= '0;
      tnb_q  <= ats_pkg::NBITS_8;
      tpar_q <= 1'b0;
      tpe_q  <= 1'b0;
      tst2_q <= 1'b0;
      tsec_q <= 1'b0;
      txd_q  <= 1'b1;
    end else begin
      tx_q   <= tx_d;
      sh_q   <= sh_d;
      tcnt_q <= tcnt_d;
      tbit_q <= tbit_d;
      tnb_q  <= tnb_d;
      tpar_q <= tpar_d;
      tpe_q  <= tpe_d;
      tst2_q <= tst2_d;
      tsec_q <= tsec_d;
      txd_q  <= txd_d;
    end
  end

  assign o_txd     = txd_q;
  assign o_tx_busy = (tx_q != ats_pkg::TX_IDLE) || !fifo_empty;

  // Receive line sync; level moves only when stages two and three agree
  always_comb begin
    rlvl_d = rlvl_q;
    if (rs2_q == rs3_q) begin
      rlvl_d = rs3_q;
    end
  end

  // Receiver checks parity and first stop only
  always_comb begin
    rx_d   = rx_q;
    rsh_d  = rsh_q;
    rcnt_d = rcnt_q;
    rbit_d = rbit_q;
    racc_d = racc_q;
    rdone  = 1'b0;
    rperr  = 1'b0;
    rferr  = 1'b0;
    rbyte  = rsh_q;
    if (!fmt_q[ats_pkg::FMT_CHR]) begin
      rbyte = rsh_q;
    end else begin
      rbyte = rsh_q >> 1;
    end
    case (rx_q)
      ats_pkg::RX_IDLE: begin
        if (ctl_q[ats_pkg::CTL_RXON] && rprev_q && !rlvl_q) begin
          rx_d   = ats_pkg::RX_START;
          rcnt_d = blen >> 1;
        end
      end
      ats_pkg::RX_START: begin
        if (rcnt_q != '0) begin
          rcnt_d = rcnt_q - 16'h0001;
        end else if (rlvl_q) begin
          rx_d = ats_pkg::RX_IDLE; // Glitch, not a start bit
        end else begin
          rx_d   = ats_pkg::RX_DATA;
          rcnt_d = blen - 16'h0001;
          rbit_d = '0;
          racc_d = 1'b0;
        end
      end
      ats_pkg::RX_DATA: begin
        if (rcnt_q != '0) begin
          rcnt_d = rcnt_q - 16'h0001;
        end else begin
          rcnt_d = blen - 16'h0001;
          rsh_d  = {rlvl_q, rsh_q[7:1]};
          racc_d = racc_q ^ rlvl_q;
          rbit_d = rbit_q + 4'h1;
          if ((rbit_q + 4'h1) == (fmt_q[ats_pkg::FMT_CHR] ? ats_pkg::NBITS_7 : ats_pkg::NBITS_8)) begin
            rx_d = fmt_q[ats_pkg::FMT_PE] ? ats_pkg::RX_PAR : ats_pkg::RX_STOP; // [RULE11]
          end
        end
      end
      ats_pkg::RX_PAR: begin
        if (rcnt_q != '0) begin
          rcnt_d = rcnt_q - 16'h0001;
        end else begin
          rcnt_d = blen - 16'h0001;
          racc_d = racc_q ^ rlvl_q;
          rx_d   = ats_pkg::RX_STOP;
        end
      end
      ats_pkg::RX_STOP: begin
        if (rcnt_q != '0) begin
          rcnt_d = rcnt_q - 16'h0001;
        end else begin
          // Back to idle at mid first stop; a low second stop is a new start [RULE16]
          rx_d  = ats_pkg::RX_IDLE;
          rdone = 1'b1;
          rferr = !rlvl_q;
          rperr = fmt_q[ats_pkg::FMT_PE] && (racc_q != fmt_q[ats_pkg::FMT_OE]); // [RULE13] [RULE14]
        end
      end
      default: begin
        rx_d = ats_pkg::RX_IDLE;
      end
    endcase
    if (i_standby) begin
      rx_d = ats_pkg::RX_IDLE;
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      rs1_q   <= 1'b1;
      rs2_q   <= 1'b1;
      rs3_q   <= 1'b1;
      rlvl_q  <= 1'b1;
      rprev_q <= 1'b1;
      rx_q    <= ats_pkg::RX_IDLE;
      rsh_q   <= '0;
      rcnt_q  <= '0;
      rbit_q  <= '0;
      racc_q  <= 1'b0;
    end else begin
      rs1_q   <= i_rxd;
      rs2_q   <= rs1_q;
      rs3_q   <= rs2_q;
      rlvl_q  <= rlvl_d;
      rprev_q <= rlvl_q;
      rx_q    <= rx_d;
      rsh_q   <= rsh_d;
      rcnt_q  <= rcnt_d;
      rbit_q  <= rbit_d;
      racc_q  <= racc_d;
    end
  end

endmodule : ats_serial
`default_nettype wire

//--- inc/ats_pkg.sv
`default_nettype none
package ats_pkg;
  // Register map on the plain register port
  localparam int unsigned ADDR_W    = 4;
  localparam logic [3:0]  A_FMT     = 4'h0;
  localparam logic [3:0]  A_CTRL    = 4'h1;
  localparam logic [3:0]  A_BRATE   = 4'h2;
  localparam logic [3:0]  A_TXPORT  = 4'h3;
  localparam logic [3:0]  A_STAT    = 4'h4;
  localparam logic [3:0]  A_RXDATA  = 4'h5;
  // frame_format_select fields
  localparam int unsigned FMT_CHR   = 6;
  localparam int unsigned FMT_PE    = 5;
  localparam int unsigned FMT_OE    = 4;
  localparam int unsigned FMT_STOP  = 3;
  localparam int unsigned FMT_CKSH  = 1;
  localparam int unsigned FMT_CKSL  = 0;
  localparam logic [7:0]  FMT_WMASK = 8'h7b;
  localparam logic [7:0]  FMT_RST   = 8'h00;
  // Control fields
  localparam int unsigned CTL_TXON  = 0;
  localparam int unsigned CTL_RXON  = 1;
  localparam int unsigned CTL_FRST  = 2;
  localparam logic [7:0]  CTL_WMASK = 8'h03;
  localparam logic [7:0]  CTL_RST   = 8'h00;
  localparam logic [7:0]  BRATE_RST = 8'hff;
  // Status fields
  localparam int unsigned ST_IDLE   = 5;
  localparam int unsigned ST_PERR   = 6;
  localparam int unsigned ST_FERR   = 7;
  // Prescale divisors
  localparam logic [1:0]  CKS_DIV1  = 2'h0;
  localparam logic [1:0]  CKS_DIV4  = 2'h1;
  localparam logic [1:0]  CKS_DIV16 = 2'h2;
  localparam logic [6:0]  PRE_1     = 7'h01;
  localparam logic [6:0]  PRE_4     = 7'h04;
  localparam logic [6:0]  PRE_16    = 7'h10;
  localparam logic [6:0]  PRE_64    = 7'h40;
  localparam logic [3:0]  NBITS_7   = 4'h7;
  localparam logic [3:0]  NBITS_8   = 4'h8;
  typedef enum logic [4:0] {
    TX_IDLE  = 5'b00001,
    TX_START = 5'b00010,
    TX_DATA  = 5'b00100,
    TX_PAR   = 5'b01000,
    TX_STOP  = 5'b10000
  } ats_tx_state_e;
  typedef enum logic [4:0] {
    RX_IDLE  = 5'b00001,
    RX_START = 5'b00010,
    RX_DATA  = 5'b00100,
    RX_PAR   = 5'b01000,
    RX_STOP  = 5'b10000
  } ats_rx_state_e;
endpackage : ats_pkg
`default_nettype wire

//--- tb/ats_serial_chk.sv
`timescale 1ns/1ns
`default_nettype none
module ats_serial_chk (
  input wire logic                       i_mclk,
  input wire logic                       i_rst,
  input wire logic                       i_standby,
  input wire logic [ats_pkg::ADDR_W-1:0] i_addr,
  input wire logic [7:0]                 i_wdata,
  input wire logic                       i_wr,
  input wire logic                       i_rd,
  input wire logic [7:0]                 o_rdata,
  input wire logic                       i_rxd,
  input wire logic                       o_txd,
  input wire logic                       o_tx_busy
);
  logic [7:0] fmt_q;
  logic [7:0] fmt_d;
  logic       on_q;
  logic       on_d;
  always_comb begin
    fmt_d = fmt_q;
    on_d  = on_q;
    if (i_wr && i_addr == ats_pkg::A_FMT) begin
      fmt_d = i_wdata & ats_pkg::FMT_WMASK;
    end
    if (i_wr && i_addr == ats_pkg::A_CTRL) begin
      on_d = i_wdata[ats_pkg::CTL_TXON];
    end
    if (i_standby) begin
      fmt_d = 8'h00;
      on_d  = 1'b0;
    end
  end
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      fmt_q <= 8'h00;
      on_q  <= 1'b0;
    end else begin
      fmt_q <= fmt_d;
      on_q  <= on_d;
    end
  end
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_rst);
  sequence s_tx_write;
    i_wr && !i_standby && i_addr == ats_pkg::A_TXPORT;
  endsequence
  // Start always lands on the second edge after the write; the window also allows the third
  sequence s_start_bit;
    ##[2:3] !o_txd;
  endsequence
  a_txd_idle_high: assert property (!o_tx_busy |-> o_txd)
    else $error("transmit line low while idle");
  a_start_after_write: assert property (on_q && !o_tx_busy ##0 s_tx_write |-> s_start_bit)
    else $error("no start bit after write");
  a_busy_after_write: assert property (s_tx_write |=> o_tx_busy)
    else $error("write to idle port not taken");
  a_port_reads_zero: assert property (i_rd && i_addr == ats_pkg::A_TXPORT |=> o_rdata == 8'h00)
    else $error("transmit port readable");
  a_fmt_readback: assert property (i_rd && i_addr == ats_pkg::A_FMT |=> o_rdata == $past(fmt_q))
    else $error("format readback wrong");
  a_fmt_reserved_zero: assert property (i_rd && i_addr == ats_pkg::A_FMT |=> !o_rdata[7] && !o_rdata[2])
    else $error("reserved format bits set");
  a_standby_clears: assert property (i_standby |=> !o_tx_busy ##1 o_txd)
    else $error("standby left transmitter running");
  a_rdata_one_cycle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data outside read cycle");
  c_start: cover property (on_q ##0 s_tx_write);
endmodule : ats_serial_chk
`default_nettype wire

//--- tb/ats_serial_far.sv
`timescale 1ns/1ns
`default_nettype none
module ats_serial_far (
  input  wire logic        i_mclk,
  input  wire logic        i_txd,
  input  var  int          i_len,
  input  var  int          i_cnt,
  output logic             o_rxd,
  output logic      [11:0] o_last,
  output int               o_count,
  output int               o_gap
);
  int          now;
  int          t0;
  logic [11:0] bits;
  initial begin
    // Line pulled up; this side never sends
    o_rxd   = 1'b1;
    o_last  = '1;
    o_count = 0;
    o_gap   = 0;
    now     = 0;
    t0      = 0;
    forever begin
      @(negedge i_mclk);
      now++;
      if (i_txd === 1'b0) begin
        o_gap = now - t0;
        t0    = now;
        bits  = '1;
        // One sample per bit period, LSB first, then parity and stops
        for (int k = 0; k < i_cnt; k++) begin
          repeat (i_len) @(negedge i_mclk);
          now += i_len;
          bits[k] = i_txd;
        end
        o_last = bits;
        o_count++;
      end
    end
  end
endmodule : ats_serial_far
`default_nettype wire

//--- tb/ats_serial_test.sv
`timescale 1ns/1ns
`default_nettype none
module ats_serial_test;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        standby = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [7:0]  wdata = 8'h00;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [7:0]  rdata;
  logic        rxd;
  logic        txd;
  logic        busy;
  int          len = 1;
  int          cnt = 9;
  logic [11:0] last;
  int          count;
  int          gap;
  int          mismatches = 0;
  int          checks_done = 0;
  int          cycles = 0;
  int          c0;
  logic [7:0]  fmts [9] = '{8'h00, 8'h40, 8'h20, 8'h30, 8'h10, 8'h28, 8'h78, 8'h08, 8'h60};
  ats_serial ats_serial_i (.i_mclk(mclk), .i_rst(rst), .i_standby(standby), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_rxd(rxd), .o_txd(txd),
    .o_tx_busy(busy));
  ats_serial_far ats_serial_far_i (.i_mclk(mclk), .i_txd(txd), .i_len(len), .i_cnt(cnt),
    .o_rxd(rxd), .o_last(last), .o_count(count), .o_gap(gap));
  always #25 mclk = ~mclk;
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : stop_test
  // Ceiling well above the longest prescale run
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      $display("wrong value run cycles expected below 20000 seen 20000");
      stop_test();
    end
  end
  task automatic chk_reg(input string n, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk_reg
  task automatic chk_frame(input string n, input logic [11:0] e, input logic [11:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk_frame
  task automatic chk_num(input string n, input int e, input int g);
    checks_done++;
    if (g != e) begin
      mismatches++;
      $display("wrong value %s expected %0d seen %0d", n, e, g);
    end
  endtask : chk_num
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input string n, input logic [3:0] a, input logic [7:0] e);
    @(posedge mclk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    @(negedge mclk);
    chk_reg(n, e, rdata);
  endtask : rd_reg
  task automatic wait_frame(input int c);
    int t;
    t = 0;
    while (count < c && t < 5000) begin
      @(posedge mclk);
      t++;
    end
    chk_num("frame count", c, count);
  endtask : wait_frame
  function automatic int len_of(input logic [7:0] f);
    return (f[ats_pkg::FMT_CHR] ? 7 : 8) + f[ats_pkg::FMT_PE] + (f[ats_pkg::FMT_STOP] ? 2 : 1);
  endfunction : len_of
  function automatic logic [11:0] frame_of(input logic [7:0] f, input logic [7:0] d);
    logic [11:0] b;
    int          n;
    n = f[ats_pkg::FMT_CHR] ? 7 : 8;
    b = '1;
    for (int k = 0; k < n; k++) begin
      b[k] = d[k];
    end
    if (f[ats_pkg::FMT_PE]) begin
      b[n] = ^(d & (n == 7 ? 8'h7f : 8'hff)) ^ f[ats_pkg::FMT_OE];
    end
    return b;
  endfunction : frame_of
  task automatic one_frame(input logic [7:0] f, input logic [7:0] d);
    cnt = len_of(f);
    wr_reg(ats_pkg::A_FMT, f);
    wr_reg(ats_pkg::A_TXPORT, d);
    wait_frame(count + 1);
    chk_frame("frame", frame_of(f, d), last);
  endtask : one_frame
  initial begin
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    rd_reg("format reset", ats_pkg::A_FMT, 8'h00);
    wr_reg(ats_pkg::A_FMT, 8'hff);
    rd_reg("format mask", ats_pkg::A_FMT, 8'h7b);
    rd_reg("tx port", ats_pkg::A_TXPORT, 8'h00);
    rd_reg("unmapped", 4'hf, 8'h00);
    @(posedge mclk);
    standby <= 1'b1;
    @(posedge mclk);
    standby <= 1'b0;
    rd_reg("format standby", ats_pkg::A_FMT, 8'h00);
    $display("test regs done");
    // Baud rate zeroed and FIFO reset before enabling
    wr_reg(ats_pkg::A_BRATE, 8'h00);
    wr_reg(ats_pkg::A_CTRL, 8'h04);
    wr_reg(ats_pkg::A_CTRL, 8'h01);
    foreach (fmts[k]) one_frame(fmts[k], 8'hb1);
    $display("test formats done");
    wr_reg(ats_pkg::A_BRATE, 8'h01);
    for (int s = 0; s < 4; s++) begin
      len = 2 * (1 << (2 * s));
      cnt = 9;
      c0  = count;
      wr_reg(ats_pkg::A_FMT, 8'(s));
      wr_reg(ats_pkg::A_TXPORT, 8'h5a);
      wr_reg(ats_pkg::A_TXPORT, 8'ha5);
      wait_frame(c0 + 2);
      chk_num("bit spacing", 10 * len, gap);
      chk_frame("second byte", frame_of(8'h00, 8'ha5), last);
    end
    $display("test prescale done");
    // Last slow stop bit is still on the line after its frame is counted
    repeat (300) @(posedge mclk);
    len = 1;
    wr_reg(ats_pkg::A_FMT, 8'h00);
    wr_reg(ats_pkg::A_BRATE, 8'h00);
    wr_reg(ats_pkg::A_CTRL, 8'h00);
    for (int i = 0; i < 17; i++) wr_reg(ats_pkg::A_TXPORT, 8'(i + 8'h40));
    rd_reg("fifo status", ats_pkg::A_STAT, 8'h30);
    c0 = count;
    wr_reg(ats_pkg::A_CTRL, 8'h01);
    for (int i = 0; i < 16; i++) begin
      wait_frame(c0 + i + 1);
      chk_frame("fifo byte", frame_of(8'h00, 8'(i + 8'h40)), last);
    end
    repeat (40) @(posedge mclk);
    chk_num("frames sent", c0 + 16, count);
    chk_reg("busy", 8'h00, {7'h00, busy});
    $display("test fifo done");
    stop_test();
  end
endmodule : ats_serial_test
bind ats_serial ats_serial_chk ats_serial_chk_i (.i_mclk, .i_rst, .i_standby, .i_addr, .i_wdata,
  .i_wr, .i_rd, .o_rdata, .i_rxd, .o_txd, .o_tx_busy);
`default_nettype wire
